// [hw/pmcsr_bank.sv]
// Power-management control/status registers reached by configuration cycles.
`timescale 1ns/1ns
`default_nettype none
module pmcsr_bank
    import pmcsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic bus_side_reset,
    input wire logic wake_request,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [5:0] cfg_dword,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic wake_out,
    output logic func_reset,
    output logic sec_clk_stop
);

    // ****************************************
    // Bus-side reset synchroniser
    // ****************************************
    logic bus_reset_sync;

    pmcsr_sync u_bus_reset_sync
    (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(bus_side_reset),
        .sync_out(bus_reset_sync)
    );

    // ****************************************
    // State update
    // ****************************************
    pmcsr_state_t state;
    pmcsr_state_t next_state;
    logic hit;
    logic [15:0] csr_view;
    logic [7:0] ext_view;
    logic clear_flag;

    always_comb
    begin
        next_state = state;
        hit = (cfg_dword == PMCSR_CSR_DWORD);
        ext_view = PMCSR_EXT_RESET;
        csr_view = 16'h0000;
        csr_view[PMCSR_FLAG_BIT] = state.wake_event_flag;
        csr_view[PMCSR_ALLOW_BIT] = state.wake_assert_allow;
        csr_view[PMCSR_STATE_LSB +: 2] = state.power_state_field;
        clear_flag = cfg_wr && hit && cfg_be[1]
            && cfg_wdata[PMCSR_FLAG_BIT];

        next_state.func_reset = 1'b0;
        next_state.rvalid = cfg_rd;
        next_state.rdata = 32'h0;
        if (cfg_rd && hit)
        begin
            next_state.rdata = {8'h00, ext_view, csr_view};
        end

        if (cfg_wr && hit)
        begin
            if (cfg_be[1])
            begin
                next_state.wake_assert_allow = cfg_wdata[PMCSR_ALLOW_BIT];
            end
            if (cfg_be[0])
            begin
                next_state.power_state_field =
                    pmcsr_pstate_t'(cfg_wdata[PMCSR_STATE_LSB +: 2]);
                // The CSR itself keeps its contents across this pulse.
                if (state.power_state_field == PMCSR_D3HOT
                    && cfg_wdata[PMCSR_STATE_LSB +: 2] == PMCSR_D0)
                begin
                    next_state.func_reset = 1'b1;
                end
            end
        end

        if (clear_flag)
        begin
            next_state.wake_event_flag = 1'b0;
        end
        if (wake_request)
        begin
            next_state.wake_event_flag = 1'b1;
        end

        // Bus-side reset spares the wake context only while wake is enabled.
        if (bus_reset_sync)
        begin
            next_state.power_state_field = PMCSR_D0;
            next_state.func_reset = 1'b0;
            if (!state.wake_assert_allow)
            begin
                next_state.wake_event_flag = wake_request;
                next_state.wake_assert_allow = 1'b0;
            end
            else
            begin
                next_state.wake_assert_allow = state.wake_assert_allow;
            end
        end

        next_state.wake_out = next_state.wake_event_flag
            && next_state.wake_assert_allow;
        next_state.sec_clk_stop = ext_view[PMCSR_BPCC_BIT]
            && ext_view[PMCSR_D3ACT_BIT]
            && next_state.power_state_field == PMCSR_D3HOT;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign cfg_rdata = state.rdata;
    assign cfg_rvalid = state.rvalid;
    assign wake_out = state.wake_out;
    assign func_reset = state.func_reset;
    assign sec_clk_stop = state.sec_clk_stop;

endmodule : pmcsr_bank
`default_nettype wire

// [hw/pmcsr_pkg.sv]
// Constants and state types for the power-management register bank.
// What this block does
// - Wake-event flag sets whenever a wake request occurs, enable or not.
// - Writing one to the wake-event flag clears it and releases the wake output, unless a wake request arrives in the same cycle.
// - Writing zero to the wake-event flag position changes nothing.
// - Data scale and data select fields always read as zeros.
// - The wake output is driven only while the wake-assert enable is set.
// - The wake-assert enable is cleared by global reset, not bus-side reset.
// - Wake context bits survive bus-side reset while wake is enabled.
// - Power state field encodes 00 D0, 01 D1, 10 D2, 11 D3hot.
// - The control/status register survives the D3hot-to-D0 internal reset.
// - A D3hot-to-D0 change resets the rest of the function's registers.
// - Reserved bits 7-2 and extension bits 5-0 read as zeros.
// - The bus power/clock control enable bit always reads as one.
// - The D3 secondary-action bit reads one: D3hot stops the secondary clock.
// - With bus power/clock control off, power state leaves secondary bus alone.
package pmcsr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [5:0] PMCSR_CSR_DWORD = 6'h29;
    localparam logic [7:0] PMCSR_CSR_OFFSET = 8'ha4;
    localparam logic [7:0] PMCSR_EXT_OFFSET = 8'ha6;
    localparam logic [15:0] PMCSR_CSR_RESET = 16'h0000;
    localparam logic [7:0] PMCSR_EXT_RESET = 8'hc0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PMCSR_FLAG_BIT = 15;
    localparam int PMCSR_ALLOW_BIT = 8;
    localparam int PMCSR_STATE_LSB = 0;
    localparam int PMCSR_BPCC_BIT = 7;
    localparam int PMCSR_D3ACT_BIT = 6;
    localparam logic [31:0] PMCSR_CYCLES_RESET = 32'h0;

    typedef enum logic [1:0]
    {
        PMCSR_D0 = 2'h0,
        PMCSR_D1 = 2'h1,
        PMCSR_D2 = 2'h2,
        PMCSR_D3HOT = 2'h3
    } pmcsr_pstate_t;

    typedef struct packed
    {
        logic wake_event_flag;
        logic wake_assert_allow;
        pmcsr_pstate_t power_state_field;
        logic wake_out;
        logic func_reset;
        logic sec_clk_stop;
        logic rvalid;
        logic [31:0] rdata;
    } pmcsr_state_t;

endpackage : pmcsr_pkg

// [hw/pmcsr_sync.sv]
// Three-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module pmcsr_sync
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic async_in,
    output var logic sync_out
);

    logic [2:0] stages;

    // The level changes only once the second and third stages agree.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stages <= 3'h0;
            sync_out <= 1'b0;
        end
        else
        begin
            stages <= {stages[1:0], async_in};
            if (stages[1] == stages[2])
            begin
                sync_out <= stages[2];
            end
        end
    end

endmodule : pmcsr_sync
`default_nettype wire

// [verif/pmcsr_chk.sv]
// Port assertions for the power-management register bank.
`timescale 1ns/1ns
`default_nettype none
module pmcsr_chk
    import pmcsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wake_request,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [5:0] cfg_dword,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic wake_out,
    input wire logic func_reset,
    input wire logic sec_clk_stop
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic hit, csr_rd, wr_hi, wr_lo;
    assign hit = cfg_dword == PMCSR_CSR_DWORD;
    assign csr_rd = cfg_rd && hit;
    assign wr_hi = cfg_wr && hit && cfg_be[1];
    assign wr_lo = cfg_wr && hit && cfg_be[0];
    sequence wake_then_read;
        wake_request ##[1:6] csr_rd;
    endsequence
    sequence d0_pulse;
        (!sec_clk_stop && $past(sec_clk_stop)) ##1 !func_reset;
    endsequence
    a_zero_fields: assert property (cfg_rvalid |->
        !{cfg_rdata[14:9], cfg_rdata[7:2]}) else $error("fixed field set");
    a_ext_const: assert property (csr_rd |=>
        cfg_rdata[23:16] == PMCSR_EXT_RESET) else $error("ext byte");
    a_wake_level: assert property (csr_rd && !cfg_wr && !wake_request |=>
        wake_out == (cfg_rdata[15] & cfg_rdata[8])) else $error("wake level");
    a_flag_sets: assert property (wake_then_read |=> cfg_rdata[15])
        else $error("flag not set");
    a_w1c_release: assert property (wr_hi && cfg_wdata[15] &&
        !wake_request |=> !wake_out) else $error("wake not released");
    a_zero_keeps: assert property (wr_hi && cfg_wdata[15:8] == 8'h01 &&
        wake_out |=> wake_out) else $error("zero write changed wake");
    a_allow_gate: assert property (wr_hi && !cfg_wdata[8] |=> !wake_out)
        else $error("wake while disabled");
    a_d3_stop: assert property (wr_lo && cfg_wdata[1:0] == 2'h3 |=>
        sec_clk_stop) else $error("clock not stopped");
    a_d0_reset: assert property (func_reset |-> d0_pulse)
        else $error("bad function reset");
endmodule : pmcsr_chk
bind pmcsr_bank pmcsr_chk u_chk (.*);
`default_nettype wire

// [verif/pmcsr_host.sv]
// Host model issuing one-cycle configuration strobes.
`timescale 1ns/1ns
`default_nettype none
module pmcsr_host
(
    input wire logic core_clk,
    output logic cfg_wr = 1'b0,
    output logic cfg_rd = 1'b0,
    output logic [5:0] cfg_dword = 6'h00,
    output logic [3:0] cfg_be = 4'h0,
    output logic [31:0] cfg_wdata = 32'h0
);
    task automatic cyc(input logic w, input logic [5:0] a,
        input logic [3:0] b, input logic [15:0] d);
        @(posedge core_clk);
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_dword <= a;
        cfg_be <= b;
        cfg_wdata <= {16'h0, d};
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
    endtask : cyc
endmodule : pmcsr_host
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the power-management register bank.
`timescale 1ns/1ns
`default_nettype none
module tb
    import pmcsr_pkg::*;
;
    logic core_clk = 0, rst = 1, bus_side_reset = 0, wake_request = 0;
    logic cfg_wr, cfg_rd, cfg_rvalid, wake_out, func_reset, sec_clk_stop;
    logic [5:0] cfg_dword;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    int failures = 0, samples_checked = 0, cycles = 0;
    // Rows: wake pulse, byte enables, write data, expected register.
    localparam logic [39:0] ROWS [10] = '{40'h0_1_0001_0001, 40'h0_1_0002_0002,
        40'h0_1_0003_0003, 40'h0_1_00fc_0000, 40'h0_2_7e00_0000,
        40'h1_2_0000_8000, 40'h0_2_0100_8100, 40'h0_2_0100_8100,
        40'h0_2_8100_0100,
        40'h1_3_0102_8102};
    pmcsr_host u_host (.*);
    pmcsr_bank u_dut (.*);
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (++cycles > 3000) report_and_stop();
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd_csr(input logic [5:0] a, input logic [31:0] exp);
        u_host.cyc(1'b0, a, 4'h0, 16'h0);
        #1 check(cfg_rdata, exp);
        check({31'h0, cfg_rvalid}, 32'h1);
    endtask : rd_csr
    task automatic wake();
        @(posedge core_clk) wake_request <= 1'b1;
        @(posedge core_clk) wake_request <= 1'b0;
    endtask : wake
    task automatic bus_reset();
        @(posedge core_clk) bus_side_reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        bus_side_reset <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : bus_reset
    task automatic report_and_stop();
        failures += int'(cycles > 3000);
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd_csr(PMCSR_CSR_DWORD, 32'h00c00000);
        foreach (ROWS[i])
        begin
            if (ROWS[i][36])
                wake();
            u_host.cyc(1'b1, PMCSR_CSR_DWORD, ROWS[i][35:32], ROWS[i][31:16]);
            #1 check({31'h0, wake_out}, {31'h0, ROWS[i][15] & ROWS[i][8]});
            rd_csr(PMCSR_CSR_DWORD, {16'h00c0, ROWS[i][15:0]});
        end
        bus_reset();
        rd_csr(PMCSR_CSR_DWORD, 32'h00c08100);
        @(posedge core_clk) rst <= 1'b1;
        @(posedge core_clk) rst <= 1'b0;
        rd_csr(PMCSR_CSR_DWORD, 32'h00c00000);
        wake();
        bus_reset();
        rd_csr(PMCSR_CSR_DWORD, 32'h00c00000);
        u_host.cyc(1'b1, 6'h2a, 4'hf, 16'h0103);
        rd_csr(6'h2a, 32'h0);
        rd_csr(PMCSR_CSR_DWORD, 32'h00c00000);
        u_host.cyc(1'b1, PMCSR_CSR_DWORD, 4'h1, 16'h0003);
        #1 check({31'h0, sec_clk_stop}, 32'h1);
        u_host.cyc(1'b1, PMCSR_CSR_DWORD, 4'h1, 16'h0000);
        #1 check({30'h0, func_reset, sec_clk_stop}, 32'h2);
        @(posedge core_clk) #1 check({31'h0, func_reset}, 32'h0);
        rd_csr(PMCSR_CSR_DWORD, 32'h00c00000);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
